// [pkg/cfm_defs.svh]
// Register offsets, bit positions, reset values and timing counts for the charger flag block
`ifndef CFM_DEFS_SVH
`define CFM_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CFM_ADDR_FLAG1 8'h0F
`define CFM_ADDR_FLAG2 8'h10
`define CFM_ADDR_FAULT 8'h11
`define CFM_ADDR_MASK_A 8'h12
`define CFM_ADDR_MASK_B 8'h13

// ----------------------------------------------------------------------------
// Reset values and implemented-bit masks
// ----------------------------------------------------------------------------
`define CFM_RESET_BYTE 8'h00
`define CFM_RESET_BIT 1'b0
`define CFM_IMPL_FLAG1 8'h79
`define CFM_IMPL_FLAG2 8'h97
`define CFM_IMPL_FAULT 8'hF1
`define CFM_IMPL_MASK_A 8'hF9
`define CFM_IMPL_MASK_B 8'h97

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CFM_FLT_OVP 7
`define CFM_FLT_THERMAL_SHUTDOWN 6
`define CFM_FLT_BATTERY_OVERVOLTAGE 5
`define CFM_FLT_TIMER 4
`define CFM_FLT_OUTFLT 0
`define CFM_F1_ILIM 6
`define CFM_F1_VLIM 5
`define CFM_F1_DIE_THERMAL_REGULATION 4
`define CFM_F1_WDOG 3
`define CFM_F1_CHG 0
`define CFM_MA_ADC 7
`define CFM_F2_PGOOD 7
`define CFM_F2_SRC 4
`define CFM_F2_THERM 2
`define CFM_F2_OPT 1
`define CFM_F2_SYSMIN 0

// ----------------------------------------------------------------------------
// Interrupt pulse timing and queue counter width
// ----------------------------------------------------------------------------
`define CFM_PULSE_CYCLES 64
`define CFM_GAP_CYCLES 16
`define CFM_PEND_W 4

`endif

// [pkg/cfm_pkg.sv]
// Types shared by the charger flag and interrupt mask block
package cfm_pkg;

    // ------------------------------------------------------------------------
    // Data types
    // ------------------------------------------------------------------------
    typedef logic [7:0] cfm_byte_type;
    typedef logic [2:0] cfm_field_type;

    // ------------------------------------------------------------------------
    // Interrupt pulse generator states
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        CFM_PS_IDLE,
        CFM_PS_LOW,
        CFM_PS_GAP
    } cfm_pulse_state_type;

endpackage

// [pkg/cfm_irq_if.sv]
// Interface between the flag logic and the interrupt pulse generator
`timescale 1ns/1ps
interface cfm_irq_if;
    logic evt;
    logic int_n;
    logic busy;

    modport src (
        output evt,
        input int_n,
        input busy
    );

    modport gen (
        input evt,
        output int_n,
        output busy
    );
endinterface // cfm_irq_if

// [rtl/cfm_pulse.sv]
// Interrupt pulse generator: one fixed-width low pulse per queued event
`timescale 1ns/1ps
`include "cfm_defs.svh"
module cfm_pulse #(
    parameter int PULSE_CYCLES = `CFM_PULSE_CYCLES,
    parameter int GAP_CYCLES = `CFM_GAP_CYCLES,
    parameter int PEND_W = `CFM_PEND_W
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    cfm_irq_if.gen irq // Event in, pulse out
);
    import cfm_pkg::*;

    localparam int CNT_W = $clog2(PULSE_CYCLES + GAP_CYCLES + 1);
    localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_CYCLES - 1);
    localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CYCLES - 1);
    localparam logic [PEND_W-1:0] PEND_FULL = '1;
    localparam logic [PEND_W-1:0] PEND_ONE = PEND_W'(1);

    // ------------------------------------------------------------------------
    // Queue of events not yet signalled
    // ------------------------------------------------------------------------
    // Saturates rather than wraps: beyond the queue depth pulses merge,
    // which only costs extra reads of already-set flags.
    cfm_pulse_state_type state_r, state_nxt;
    logic [PEND_W-1:0] pend_r, pend_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;
    logic start;
    logic add;

    assign start = (state_r == CFM_PS_IDLE) && (pend_r != '0);
    assign add = irq.evt && (pend_r != PEND_FULL);
    assign pend_nxt = pend_r + (add ? PEND_ONE : '0) - (start ? PEND_ONE : '0);

    // ------------------------------------------------------------------------
    // Pulse sequencing
    // ------------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        case (state_r)
            CFM_PS_IDLE: begin
                cnt_nxt = '0;
                if (start) begin
                    state_nxt = CFM_PS_LOW;
                end
            end
            CFM_PS_LOW: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == PULSE_LAST) begin
                    state_nxt = CFM_PS_GAP;
                    cnt_nxt = '0;
                end
            end
            CFM_PS_GAP: begin
                cnt_nxt = cnt_r + 1'b1;
                if (cnt_r == GAP_LAST) begin
                    state_nxt = CFM_PS_IDLE;
                    cnt_nxt = '0;
                end
            end
            default: begin
                state_nxt = CFM_PS_IDLE;
                cnt_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_r <= CFM_PS_IDLE;
            cnt_r <= '0;
            pend_r <= '0;
            irq.int_n <= 1'b1;
            irq.busy <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            pend_r <= pend_nxt;
            irq.int_n <= (state_nxt != CFM_PS_LOW);
            irq.busy <= (state_nxt != CFM_PS_IDLE) || (pend_nxt != '0);
        end
    end
endmodule // cfm_pulse

// [rtl/cfm_top.sv]
// Charger event flags, fault flags, interrupt masks and interrupt pulse output
`timescale 1ns/1ps
`include "cfm_defs.svh"
module cfm_top #(
    parameter int PULSE_CYCLES = `CFM_PULSE_CYCLES,
    parameter int GAP_CYCLES = `CFM_GAP_CYCLES,
    parameter int PEND_W = `CFM_PEND_W
) (
    input wire logic clk, // System clock, 250 MHz
    input wire logic rst_n, // Synchronous reset, active low
    // Register port from the serial control bus front end
    input wire logic reg_rd_en, // Read strobe, one cycle
    input wire logic reg_wr_en, // Write strobe, one cycle
    input wire cfm_pkg::cfm_byte_type reg_addr, // Register offset
    input wire cfm_pkg::cfm_byte_type reg_wdata, // Write data
    input wire logic reg_reset_req, // Software register reset, one cycle
    output cfm_pkg::cfm_byte_type reg_rdata_r, // Read data, held until next read
    output logic reg_ack_r, // Access taken, one cycle
    output logic reg_hit_r, // Last access hit a register of this block
    // Fault status sources
    input wire logic input_overvoltage, // Input overvoltage fault level
    input wire logic thermal_shutdown, // Thermal shutdown fault level
    input wire logic battery_overvoltage, // Battery overvoltage fault level
    input wire logic safety_timer_expired, // Charge safety timer expired level
    input wire logic output_mode_fault_status, // Output buck mode fault level
    input wire cfm_pkg::cfm_byte_type fault_int_mask, // Fault interrupt mask bits
    // Charger status sources
    input wire logic adc_done, // Conversion complete level
    input wire logic adc_one_shot, // Converter in one-shot mode
    input wire logic input_current_limit_regulation, // In input current limit
    input wire logic input_voltage_limit_regulation, // In input voltage limit
    input wire logic die_thermal_regulation, // In die thermal regulation
    input wire logic bus_watchdog_status, // Bus watchdog expired level
    input wire cfm_pkg::cfm_field_type charge_state_field, // Charge state
    input wire logic power_good, // Input power good level
    input wire cfm_pkg::cfm_field_type input_source_field, // Input source type
    input wire cfm_pkg::cfm_field_type thermistor_zone_field, // Thermistor zone
    input wire logic current_optimizer_status, // Input current optimizer status
    input wire logic system_minimum_voltage, // In system minimum regulation
    // Outputs
    output logic int_n, // Interrupt pulse, active low
    output logic flag_pending_r // Some flag bit is set
);
    import cfm_pkg::*;

    localparam int NST = 12;
    localparam int NFLAG = 24;

    // ------------------------------------------------------------------------
    // Status history for edge and change detection
    // ------------------------------------------------------------------------
    // History loads the live value during reset so a status already high
    // when reset releases does not fake an edge.
    logic [NST-1:0] st_now, st_prev_r, st_rise, st_tog;
    cfm_field_type chg_prev_r, src_prev_r, thm_prev_r;
    logic chg_changed, src_changed, thm_changed;

    assign st_now = {
        input_overvoltage,
        thermal_shutdown,
        battery_overvoltage,
        safety_timer_expired,
        output_mode_fault_status,
        adc_done,
        input_current_limit_regulation,
        input_voltage_limit_regulation,
        die_thermal_regulation,
        bus_watchdog_status,
        power_good,
        current_optimizer_status
    };

    always_ff @(posedge clk) begin
        st_prev_r <= st_now;
        chg_prev_r <= charge_state_field;
        src_prev_r <= input_source_field;
        thm_prev_r <= thermistor_zone_field;
    end

    assign st_rise = st_now & ~st_prev_r;
    assign st_tog = st_now ^ st_prev_r;
    assign chg_changed = rst_n && (charge_state_field != chg_prev_r);
    assign src_changed = rst_n && (input_source_field != src_prev_r);
    assign thm_changed = rst_n && (thermistor_zone_field != thm_prev_r);

    logic sysmin_prev_r;
    logic sysmin_edge;

    always_ff @(posedge clk) begin
        sysmin_prev_r <= system_minimum_voltage;
    end

    assign sysmin_edge = rst_n && (system_minimum_voltage != sysmin_prev_r);

    // ------------------------------------------------------------------------
    // Event set vectors, one byte per flag register
    // ------------------------------------------------------------------------
    cfm_byte_type set_fault, set_f1, set_f2;
    logic adc_evt;

    always_comb begin
        set_fault = `CFM_RESET_BYTE;
        set_fault[`CFM_FLT_OVP] = rst_n && st_rise[11];
        set_fault[`CFM_FLT_THERMAL_SHUTDOWN] = rst_n && st_rise[10];
        set_fault[`CFM_FLT_BATTERY_OVERVOLTAGE] = rst_n && st_rise[9];
        set_fault[`CFM_FLT_TIMER] = rst_n && st_rise[8];
        set_fault[`CFM_FLT_OUTFLT] = rst_n && st_rise[7];
    end

    always_comb begin
        set_f1 = `CFM_RESET_BYTE;
        set_f1[`CFM_F1_ILIM] = rst_n && st_rise[5];
        set_f1[`CFM_F1_VLIM] = rst_n && st_rise[4];
        set_f1[`CFM_F1_DIE_THERMAL_REGULATION] = rst_n && st_rise[3];
        set_f1[`CFM_F1_WDOG] = rst_n && st_rise[2];
        set_f1[`CFM_F1_CHG] = chg_changed;
    end

    always_comb begin
        set_f2 = `CFM_RESET_BYTE;
        set_f2[`CFM_F2_PGOOD] = rst_n && st_tog[1];
        set_f2[`CFM_F2_SRC] = src_changed;
        set_f2[`CFM_F2_THERM] = thm_changed;
        set_f2[`CFM_F2_OPT] = rst_n && st_rise[0];
        set_f2[`CFM_F2_SYSMIN] = sysmin_edge;
    end

    // Conversion done has no flag bit of its own; it only raises a pulse
    assign adc_evt = rst_n && st_rise[6];

    // ------------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------------
    logic sel_f1, sel_f2, sel_fault, sel_ma, sel_mb, sel_any;
    logic rd_f1, rd_f2, rd_fault;
    logic wr_ma, wr_mb;

    assign sel_f1 = (reg_addr == `CFM_ADDR_FLAG1);
    assign sel_f2 = (reg_addr == `CFM_ADDR_FLAG2);
    assign sel_fault = (reg_addr == `CFM_ADDR_FAULT);
    assign sel_ma = (reg_addr == `CFM_ADDR_MASK_A);
    assign sel_mb = (reg_addr == `CFM_ADDR_MASK_B);
    assign sel_any = sel_f1 || sel_f2 || sel_fault || sel_ma || sel_mb;
    assign rd_f1 = reg_rd_en && sel_f1;
    assign rd_f2 = reg_rd_en && sel_f2;
    assign rd_fault = reg_rd_en && sel_fault;
    // Writes to the flag registers are dropped: they are read only
    assign wr_ma = reg_wr_en && !reg_rd_en && sel_ma;
    assign wr_mb = reg_wr_en && !reg_rd_en && sel_mb;

    // ------------------------------------------------------------------------
    // Sticky flag bits
    // ------------------------------------------------------------------------
    // A set in the same cycle as a read clear or register reset wins, so
    // an event arriving under a read is reported by the next read.
    logic [NFLAG-1:0] flag_r, flag_nxt, set_all, clr_all, impl_all;

    assign impl_all = {`CFM_IMPL_FAULT, `CFM_IMPL_FLAG2, `CFM_IMPL_FLAG1};
    assign set_all = {set_fault, set_f2, set_f1};
    assign clr_all = {{8{rd_fault}}, {8{rd_f2}}, {8{rd_f1}}} | {NFLAG{reg_reset_req}};

    genvar gi;
    generate
        for (gi = 0; gi < NFLAG; gi++) begin : g_flag
            assign flag_nxt[gi] = impl_all[gi] && (set_all[gi] || (flag_r[gi] && !clr_all[gi]));
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    flag_r[gi] <= `CFM_RESET_BIT;
                end else begin
                    flag_r[gi] <= flag_nxt[gi];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Mask registers
    // ------------------------------------------------------------------------
    // Watchdog expiry is deliberately not an input: masks survive it.
    cfm_byte_type mask_a_r, mask_a_nxt, mask_b_r, mask_b_nxt;

    assign mask_a_nxt = reg_reset_req ? `CFM_RESET_BYTE
                      : wr_ma ? (reg_wdata & `CFM_IMPL_MASK_A) : mask_a_r;
    assign mask_b_nxt = reg_reset_req ? `CFM_RESET_BYTE
                      : wr_mb ? (reg_wdata & `CFM_IMPL_MASK_B) : mask_b_r;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mask_a_r <= `CFM_RESET_BYTE;
            mask_b_r <= `CFM_RESET_BYTE;
        end else begin
            mask_a_r <= mask_a_nxt;
            mask_b_r <= mask_b_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------------------
    // Mask bit positions equal flag bit positions, so each byte gates in one
    // step; all events of one cycle merge into a single pulse request.
    cfm_byte_type unmasked_f1, unmasked_f2, unmasked_fault;
    logic adc_unmasked;
    logic int_req;
    cfm_irq_if irq ();

    assign unmasked_f1 = set_f1 & ~mask_a_r;
    assign unmasked_f2 = set_f2 & ~mask_b_r;
    assign unmasked_fault = set_fault & ~fault_int_mask;
    assign adc_unmasked = adc_evt && adc_one_shot && !mask_a_r[`CFM_MA_ADC];
    assign int_req = (|unmasked_f1) || (|unmasked_f2) || (|unmasked_fault) || adc_unmasked;
    assign irq.evt = int_req;

    cfm_pulse #(
        .PULSE_CYCLES(PULSE_CYCLES),
        .GAP_CYCLES(GAP_CYCLES),
        .PEND_W(PEND_W)
    ) u_pulse (
        .clk(clk),
        .rst_n(rst_n),
        .irq(irq)
    );

    assign int_n = irq.int_n;

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    // Read data shows the flags as they were before the clearing read.
    cfm_byte_type rdata_nxt;

    assign rdata_nxt = sel_f1 ? flag_r[7:0]
                     : sel_f2 ? flag_r[15:8]
                     : sel_fault ? flag_r[23:16]
                     : sel_ma ? mask_a_r
                     : sel_mb ? mask_b_r
                     : `CFM_RESET_BYTE;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata_r <= `CFM_RESET_BYTE;
            reg_ack_r <= 1'b0;
            reg_hit_r <= 1'b0;
            flag_pending_r <= 1'b0;
        end else begin
            if (reg_rd_en) begin
                reg_rdata_r <= rdata_nxt;
            end
            reg_ack_r <= reg_rd_en || reg_wr_en;
            if (reg_rd_en || reg_wr_en) begin
                reg_hit_r <= sel_any;
            end
            flag_pending_r <= |flag_nxt;
        end
    end
endmodule // cfm_top

// [bench/cfm_top_checker.sv]
// Concurrent checks on the ports of the charger flag and interrupt mask block
`timescale 1ns/1ps
module cfm_top_checker #(
    parameter int PULSE_CYCLES = 64,
    parameter int GAP_CYCLES = 16
) (
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic reg_rd_en, // Read strobe
    input wire logic reg_wr_en, // Write strobe
    input wire cfm_pkg::cfm_byte_type reg_addr, // Register offset
    input wire cfm_pkg::cfm_byte_type reg_rdata_r, // Read data
    input wire logic reg_ack_r, // Access taken
    input wire logic reg_hit_r, // Access hit a register
    input wire logic input_overvoltage, // Input overvoltage level
    input wire logic int_n, // Interrupt pulse, active low
    input wire logic flag_pending_r // Some flag set
);
    import cfm_pkg::*;
    logic [7:0] low_cnt_r, low_cnt_nxt, high_cnt_r, high_cnt_nxt;

    // ------------------------------------------------------------------
    // Pulse and gap length counters
    // ------------------------------------------------------------------
    // High run saturates so an idle line never wraps into a short gap
    assign low_cnt_nxt = int_n ? 8'h00 : low_cnt_r + 8'h01;
    assign high_cnt_nxt = !int_n ? 8'h00 : (&high_cnt_r ? high_cnt_r : high_cnt_r + 8'h01);
    always_ff @(posedge clk) begin
        low_cnt_r <= rst_n ? low_cnt_nxt : 8'h00;
        high_cnt_r <= rst_n ? high_cnt_nxt : 8'hFF;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_ack_after_strobe: assert property ((reg_rd_en || reg_wr_en) |=> reg_ack_r)
        else $error("no acknowledge after an access");
    chk_no_stray_ack: assert property (!(reg_rd_en || reg_wr_en) |=> !reg_ack_r)
        else $error("acknowledge without an access");
    chk_unmapped_read_zero: assert property (reg_rd_en && (reg_addr < 8'h0F || reg_addr > 8'h13)
        |=> reg_rdata_r == 8'h00 && !reg_hit_r)
        else $error("unmapped read not zero");
    chk_mapped_read_hit: assert property (reg_rd_en && reg_addr inside {[8'h0F:8'h13]}
        |=> reg_hit_r)
        else $error("mapped read without hit");
    chk_fault_spare_zero: assert property (reg_rd_en && reg_addr == 8'h11
        |=> reg_rdata_r[3:1] == 3'h0)
        else $error("fault spare bits not zero");
    chk_mask_spare_zero: assert property (reg_rd_en && reg_addr == 8'h12
        |=> reg_rdata_r[2:1] == 2'h0)
        else $error("mask A spare bits not zero");
    chk_mask_b_spare: assert property (reg_rd_en && reg_addr == 8'h13
        |=> reg_rdata_r[6:5] == 2'h0 && !reg_rdata_r[3])
        else $error("mask B spare bits not zero");
    chk_pulse_width_fixed: assert property ($rose(int_n) |-> low_cnt_r == PULSE_CYCLES)
        else $error("interrupt pulse width wrong");
    chk_pulse_gap_kept: assert property ($fell(int_n) |-> high_cnt_r >= GAP_CYCLES + 1)
        else $error("interrupt pulses too close");
    chk_fault_sets_pending: assert property ($rose(input_overvoltage)
        |-> ##[1:2] flag_pending_r)
        else $error("fault entry left no flag pending");
endmodule // cfm_top_checker

bind cfm_top cfm_top_checker #(.PULSE_CYCLES(PULSE_CYCLES), .GAP_CYCLES(GAP_CYCLES)) chk_u (
    .clk(clk), .rst_n(rst_n), .reg_rd_en(reg_rd_en), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_rdata_r(reg_rdata_r), .reg_ack_r(reg_ack_r),
    .reg_hit_r(reg_hit_r), .input_overvoltage(input_overvoltage), .int_n(int_n),
    .flag_pending_r(flag_pending_r));

// [bench/cfm_host_model.sv]
// Host side of the register port: single byte reads and writes
`timescale 1ns/1ps
module cfm_host_model (
    input wire logic clk, // System clock
    output logic reg_rd_en, // Read strobe
    output logic reg_wr_en, // Write strobe
    output cfm_pkg::cfm_byte_type reg_addr, // Register offset
    output cfm_pkg::cfm_byte_type reg_wdata, // Write data
    input wire cfm_pkg::cfm_byte_type reg_rdata_r, // Read data
    input wire logic reg_ack_r // Access taken
);
    import cfm_pkg::*;
    int miss_count = 0;
    initial begin
        reg_rd_en = 1'b0;
        reg_wr_en = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // One-cycle strobe; idle lines show the inverse so stale values never pass
    task automatic access(input logic w, input cfm_byte_type a, input cfm_byte_type d,
                          output cfm_byte_type q);
        @(negedge clk);
        reg_rd_en = !w;
        reg_wr_en = w;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_rd_en = 1'b0;
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        q = reg_rdata_r;
        if (reg_ack_r !== 1'b1) begin
            miss_count++;
            $display("unexpected at %0t: no acknowledge", $time);
        end
    endtask
endmodule // cfm_host_model

// [bench/cfm_top_tb.sv]
// Self-checking testbench for the charger flag and interrupt mask block
`timescale 1ns/1ps
module cfm_top_tb;
    import cfm_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_reset_req = 1'b0;
    logic rd_en, wr_en, ack, hit, int_n, pend;
    cfm_byte_type addr, wdata, rdata, q;
    cfm_byte_type fmask = 8'h00;
    logic [4:0] flt = 5'h00;
    logic [6:0] lv = 7'h00;
    logic adone = 1'b0;
    logic aone = 1'b0;
    cfm_field_type chg = 3'h0, src = 3'h0, thz = 3'h0;
    int bad_count = 0, total_checks = 0, falls = 0;
    int fb[5] = '{7, 6, 5, 4, 0};
    int bt[10] = '{6, 5, 4, 3, 0, 7, 4, 2, 1, 0};

    initial forever #2 clk = ~clk;
    always @(negedge int_n) falls++;

    cfm_top #(.PULSE_CYCLES(4), .GAP_CYCLES(2), .PEND_W(3)) dut_u (
        .clk(clk), .rst_n(rst_n), .reg_rd_en(rd_en), .reg_wr_en(wr_en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_reset_req(reg_reset_req), .reg_rdata_r(rdata),
        .reg_ack_r(ack), .reg_hit_r(hit), .input_overvoltage(flt[0]),
        .thermal_shutdown(flt[1]), .battery_overvoltage(flt[2]),
        .safety_timer_expired(flt[3]), .output_mode_fault_status(flt[4]),
        .fault_int_mask(fmask), .adc_done(adone), .adc_one_shot(aone),
        .input_current_limit_regulation(lv[0]), .input_voltage_limit_regulation(lv[1]),
        .die_thermal_regulation(lv[2]), .bus_watchdog_status(lv[3]),
        .charge_state_field(chg), .power_good(lv[4]), .input_source_field(src),
        .thermistor_zone_field(thz), .current_optimizer_status(lv[5]),
        .system_minimum_voltage(lv[6]), .int_n(int_n), .flag_pending_r(pend));
    cfm_host_model host_u (.clk(clk), .reg_rd_en(rd_en), .reg_wr_en(wr_en), .reg_addr(addr),
        .reg_wdata(wdata), .reg_rdata_r(rdata), .reg_ack_r(ack));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input cfm_byte_type got, input cfm_byte_type exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input cfm_byte_type a);
        host_u.access(1'b0, a, 8'h00, q);
    endtask
    task automatic wr(input cfm_byte_type a, input cfm_byte_type d);
        cfm_byte_type unused;
        host_u.access(1'b1, a, d, unused);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Level sources get a one-cycle rise; two-edge sources and fields just move
    task automatic fire(input int i);
        case (i)
            4: chg = chg + 3'h1;
            6: src = src + 3'h1;
            7: thz = thz + 3'h1;
            5: lv[4] = ~lv[4];
            9: lv[6] = ~lv[6];
            default: begin
                lv[i < 4 ? i : 5] = 1'b1;
                idle(1);
                lv[i < 4 ? i : 5] = 1'b0;
            end
        endcase
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_vals;
        for (int a = 15; a <= 19; a++) begin
            rd(8'(a));
            chk(q, 8'h00);
        end
    endtask
    task automatic t_mask_access;
        wr(8'h12, 8'hFF);
        wr(8'h13, 8'hFF);
        wr(8'h11, 8'hFF);
        rd(8'h12);
        chk(q, 8'hF9);
        rd(8'h13);
        chk(q, 8'h97);
        rd(8'h11);
        chk(q, 8'h00);
        rd(8'h3C);
        chk(q, 8'h00);
        chk({7'h00, hit}, 8'h00);
        wr(8'h12, 8'h00);
        wr(8'h13, 8'h00);
    endtask
    // Second pass masks each fault: flag must still set, pulse must not come
    task automatic t_faults;
        int p;
        for (int k = 0; k < 10; k++) begin
            p = falls;
            fmask = k < 5 ? 8'h00 : 8'h01 << fb[k % 5];
            flt[k % 5] = 1'b1;
            idle(1);
            flt[k % 5] = 1'b0;
            idle(12);
            chk({7'h00, pend}, 8'h01);
            rd(8'h11);
            chk(q, 8'h01 << fb[k % 5]);
            chk(8'(falls - p), 8'(k < 5));
            chk({7'h00, pend}, 8'h00);
            rd(8'h11);
            chk(q, 8'h00);
        end
        fmask = 8'h00;
    endtask
    task automatic t_events;
        int p;
        cfm_byte_type fa;
        for (int m = 0; m < 2; m++) begin
            for (int i = 0; i < 10; i++) begin
                fa = i < 5 ? 8'h0F : 8'h10;
                wr(fa + 8'h03, 8'(m) << bt[i]);
                p = falls;
                fire(i);
                idle(12);
                rd(fa);
                chk(q, 8'h01 << bt[i]);
                chk(8'(falls - p), 8'(1 - m));
                wr(fa + 8'h03, 8'h00);
            end
        end
    endtask
    task automatic t_adc;
        int p;
        for (int c = 0; c < 3; c++) begin
            aone = c != 2;
            wr(8'h12, c == 1 ? 8'h80 : 8'h00);
            p = falls;
            adone = 1'b1;
            idle(1);
            adone = 1'b0;
            idle(12);
            chk(8'(falls - p), c == 0 ? 8'h01 : 8'h00);
        end
    endtask
    task automatic t_reg_reset;
        wr(8'h12, 8'hFF);
        wr(8'h13, 8'hFF);
        flt[0] = 1'b1;
        idle(1);
        flt[0] = 1'b0;
        idle(12);
        reg_reset_req = 1'b1;
        idle(1);
        reg_reset_req = 1'b0;
        for (int a = 17; a <= 19; a++) begin
            rd(8'(a));
            chk(q, 8'h00);
        end
        // A fault entry in the register reset cycle must survive it
        reg_reset_req = 1'b1;
        flt[1] = 1'b1;
        idle(1);
        reg_reset_req = 1'b0;
        flt[1] = 1'b0;
        rd(8'h11);
        chk(q, 8'h40);
    endtask
    // Status already high at a mid-run reset release must not fake an edge
    task automatic t_mid_reset;
        int p;
        p = falls;
        lv[0] = 1'b1;
        rst_n = 1'b0;
        idle(2);
        rst_n = 1'b1;
        idle(12);
        chk({7'h00, pend}, 8'h00);
        rd(8'h0F);
        chk(q, 8'h00);
        chk(8'(falls - p), 8'h00);
        lv[0] = 1'b0;
    endtask

    task automatic finish_test;
        bad_count += host_u.miss_count;
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        t_reset_vals();
        t_mask_access();
        t_faults();
        t_events();
        t_adc();
        t_reg_reset();
        t_mid_reset();
        finish_test();
    end
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        $display("unexpected at %0t: run did not finish", $time);
        finish_test();
    end
endmodule // cfm_top_tb
